// [verilog/tac_pkg.sv]
/*
 tooth angle counter package: register map, field positions, reset values,
 mode encoding and timing constants.
 assumes a 32-bit apb slave with byte addresses on word boundaries.
*/
package tac_pkg;
	localparam int             TAC_ADDR_W       = 8;
	localparam int             TAC_CNT_W        = 24;
	localparam int             TAC_RATIO_W      = 8;
	localparam int             TAC_RATE_W       = 16;
	localparam int             TAC_TPT_W        = 16;
	localparam int             TAC_MISS_W       = 2;
	localparam int             TAC_LEFT_W       = 18;
	// system clocks per microcycle
	localparam int             TAC_MICRO_CLKS   = 2;

	localparam logic [7:0]     OFF_CTRL         = 8'h00;
	localparam logic [7:0]     OFF_TOOTH        = 8'h04;
	localparam logic [7:0]     OFF_RATE         = 8'h08;
	localparam logic [7:0]     OFF_TPT          = 8'h0c;
	localparam logic [7:0]     OFF_STATUS       = 8'h10;
	localparam logic [7:0]     OFF_FIRST        = 8'h14;
	localparam logic [7:0]     OFF_ANGLE        = 8'h18;
	localparam logic [7:0]     OFF_BUS          = 8'h1c;

	localparam int             CTRL_ENABLE_BIT  = 0;
	localparam int             CTRL_EXPORT_BIT  = 1;
	localparam int             CTRL_PRE1_LSB    = 8;
	localparam int             CTRL_PRE2_LSB    = 16;
	localparam int             TOOTH_LAST_BIT   = 0;
	localparam int             TOOTH_MISS_LSB   = 8;
	localparam int             STAT_MODE_LSB    = 0;
	localparam int             STAT_PEND_BIT    = 2;
	localparam int             STAT_LEFT_LSB    = 8;

	localparam logic [7:0]     PRE1_RST         = 8'h01;
	localparam logic [7:0]     PRE2_RST         = 8'h01;
	localparam logic [15:0]    RATE_RST         = 16'h0001;
	localparam logic [15:0]    TPT_RST          = 16'h0001;

	typedef enum logic [1:0] {
		TAC_NORMAL = 2'b00,
		TAC_HIGH   = 2'b01,
		TAC_HALT   = 2'b10
	} tac_mode_t;
endpackage

// [verilog/tac_prescaler.sv]
/*
 microcycle prescaler: one strobe every ratio microcycles while run is high.
 assumes run and ratio come from logic on pclk; ratio 0 acts as 1.
*/
module tac_prescaler #(
	parameter int RATIO_W = tac_pkg::TAC_RATIO_W
) (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               run,
	input  wire logic [RATIO_W-1:0] ratio,
	output logic                    strobe
);
	import tac_pkg::*;

	logic               phase_q;
	logic [RATIO_W-1:0] cnt_q;
	wire  [RATIO_W-1:0] cnt_next = cnt_q + {{(RATIO_W-1){1'b0}}, 1'b1};
	wire                wrap     = phase_q && (cnt_next >= ratio);

	// phase toggles once per clock, two clocks make a microcycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_q <= 1'b0;
			cnt_q   <= '0;
			strobe  <= 1'b0;
		end else if (!run) begin
			phase_q <= 1'b0;
			cnt_q   <= '0;
			strobe  <= 1'b0;
		end else begin
			phase_q <= ~phase_q;
			strobe  <= wrap;
			if (phase_q) begin
				cnt_q <= wrap ? '0 : cnt_next;
			end
		end
	end
endmodule

// [verilog/tac_tooth_angle_counter.sv]
/*
 tooth angle counter: follows wheel teeth, runs normal, high rate and halt
 modes, drives the second timebase counter and exports it on the shared bus.
 assumes an apb master on pclk and an asynchronous tooth pin.
*/

module tac_tooth_angle_counter (
	input  wire logic                           pclk,
	input  wire logic                           presetn,
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [tac_pkg::TAC_ADDR_W-1:0] paddr,
	input  wire logic [31:0]                    pwdata,
	output logic      [31:0]                    prdata,
	output logic                                pready,
	output logic                                pslverr,
	input  wire logic                           tooth_pin,
	output logic      [tac_pkg::TAC_CNT_W-1:0]  first_timebase_counter,
	output logic      [tac_pkg::TAC_CNT_W-1:0]  shared_time_counter_bus,
	output logic                                shared_bus_valid
);
	import tac_pkg::*;

	function automatic logic [TAC_LEFT_W-1:0] calc_span(input logic [TAC_TPT_W-1:0] tpt,
		input logic [TAC_MISS_W-1:0] miss);
		logic [TAC_LEFT_W-1:0] m;
		m = {{(TAC_LEFT_W-TAC_MISS_W){1'b0}}, miss} + {{(TAC_LEFT_W-1){1'b0}}, 1'b1};
		calc_span = TAC_LEFT_W'({2'b00, tpt} * m);
	endfunction

	// register state
	logic                    tb_en_q;
	logic                    tb_en_d1_q;
	logic                    export_q;
	logic [TAC_RATIO_W-1:0]  pre1_q;
	logic [TAC_RATIO_W-1:0]  pre2_q;
	logic                    last_q;
	logic [TAC_MISS_W-1:0]   miss_q;
	logic [TAC_RATE_W-1:0]   rate_q;
	logic [TAC_TPT_W-1:0]    tpt_q;

	// engine state
	tac_mode_t               mode_q;
	tac_mode_t               mode_d;
	logic [TAC_CNT_W-1:0]    angle_cnt_q;
	logic [TAC_CNT_W-1:0]    angle_cnt_d;
	logic [TAC_LEFT_W-1:0]   left_q;
	logic [TAC_LEFT_W-1:0]   left_d;
	logic [TAC_LEFT_W-1:0]   pend_q;
	logic [TAC_LEFT_W-1:0]   pend_d;
	logic                    pend_v_q;
	logic                    pend_v_d;
	logic [TAC_RATE_W-1:0]   rate_cnt_q;
	logic [TAC_RATE_W-1:0]   rate_cnt_d;
	logic                    sync1_q;
	logic                    sync2_q;
	logic                    sync3_q;
	logic                    strobe1;
	logic                    strobe2;
	logic                    tooth_evt;

	// apb decode
	wire setup_acc  = psel && penable && !pready;
	wire wr_acc     = psel && penable && pready && pwrite;
	wire wr_ctrl    = wr_acc && (paddr == OFF_CTRL);
	wire wr_tooth   = wr_acc && (paddr == OFF_TOOTH);
	wire wr_rate    = wr_acc && (paddr == OFF_RATE);
	wire wr_tpt     = wr_acc && (paddr == OFF_TPT);
	wire mapped     = (paddr[1:0] == 2'b00) && (paddr <= OFF_BUS);

	wire [31:0] rd_ctrl   = {8'h00, pre2_q, pre1_q, 6'h00, export_q, tb_en_q};
	wire [31:0] rd_tooth  = {22'h000000, miss_q, 7'h00, last_q};
	wire [31:0] rd_status = {6'h00, left_q, 5'h00, pend_v_q, mode_q};
	wire [31:0] rd_mux    = (paddr == OFF_CTRL)   ? rd_ctrl :
	                        (paddr == OFF_TOOTH)  ? rd_tooth :
	                        (paddr == OFF_RATE)   ? {16'h0000, rate_q} :
	                        (paddr == OFF_TPT)    ? {16'h0000, tpt_q} :
	                        (paddr == OFF_STATUS) ? rd_status :
	                        (paddr == OFF_FIRST)  ? {8'h00, first_timebase_counter} :
	                        (paddr == OFF_ANGLE)  ? {8'h00, angle_cnt_q} :
	                        (paddr == OFF_BUS)    ? {8'h00, shared_time_counter_bus} : 32'h0000_0000;

	// one wait state keeps prdata straight from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup_acc;
			prdata  <= (setup_acc && !pwrite && mapped) ? rd_mux : 32'h0000_0000;
			pslverr <= setup_acc && !mapped;
		end
	end

	// software write wins over the hardware clear of the flag
	wire last_clr = tooth_evt && last_q;
	wire last_d   = wr_tooth ? pwdata[TOOTH_LAST_BIT] : (last_clr ? 1'b0 : last_q);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tb_en_q   <= 1'b0;
			export_q  <= 1'b0;
			pre1_q    <= PRE1_RST;
			pre2_q    <= PRE2_RST;
			last_q    <= 1'b0;
			miss_q    <= '0;
			rate_q    <= RATE_RST;
			tpt_q     <= TPT_RST;
		end else begin
			last_q <= last_d;
			if (wr_ctrl) begin
				tb_en_q  <= pwdata[CTRL_ENABLE_BIT];
				export_q <= pwdata[CTRL_EXPORT_BIT];
				pre1_q   <= pwdata[CTRL_PRE1_LSB +: TAC_RATIO_W];
				pre2_q   <= pwdata[CTRL_PRE2_LSB +: TAC_RATIO_W];
			end
			// only software touches the count, so high rate cannot wipe it
			if (wr_tooth) begin
				miss_q <= pwdata[TOOTH_MISS_LSB +: TAC_MISS_W];
			end
			if (wr_rate) begin
				rate_q <= pwdata[TAC_RATE_W-1:0];
			end
			if (wr_tpt) begin
				tpt_q <= pwdata[TAC_TPT_W-1:0];
			end
		end
	end

	// second prescaler starts one clock after the first, inside one microcycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tb_en_d1_q <= 1'b0;
		end else begin
			tb_en_d1_q <= tb_en_q;
		end
	end

	tac_prescaler #(.RATIO_W(TAC_RATIO_W)) u_pre1 (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (tb_en_q),
		.ratio   (pre1_q),
		.strobe  (strobe1)
	);

	tac_prescaler #(.RATIO_W(TAC_RATIO_W)) u_pre2 (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (tb_en_d1_q),
		.ratio   (pre2_q),
		.strobe  (strobe2)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_timebase_counter <= '0;
		end else if (strobe1) begin
			first_timebase_counter <= first_timebase_counter + {{(TAC_CNT_W-1){1'b0}}, 1'b1};
		end
	end

	// tooth pin synchroniser, edge taken from the second and third stages
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
		end else begin
			sync1_q <= tooth_pin;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end
	assign tooth_evt = sync2_q && !sync3_q;

	// angle tick: rate strobes per tick in normal, one per strobe in high rate
	wire [TAC_RATE_W-1:0] rate_next = rate_cnt_q + {{(TAC_RATE_W-1){1'b0}}, 1'b1};
	wire                  rate_hit  = rate_next >= rate_q;
	wire                  left_nz   = left_q != '0;
	wire                  angle_tick = strobe2 && left_nz &&
	                                  ((mode_q == TAC_HIGH) || ((mode_q == TAC_NORMAL) && rate_hit));
	wire [TAC_LEFT_W-1:0] left_dec  = angle_tick ? left_q - {{(TAC_LEFT_W-1){1'b0}}, 1'b1} : left_q;
	wire [TAC_CNT_W-1:0]  angle_inc = angle_tick ? angle_cnt_q + {{(TAC_CNT_W-1){1'b0}}, 1'b1} : angle_cnt_q;
	wire [TAC_LEFT_W-1:0] span      = calc_span(tpt_q, miss_q);

	always_comb begin
		mode_d    = mode_q;
		angle_cnt_d = angle_inc;
		left_d    = left_dec;
		pend_d    = pend_q;
		pend_v_d  = pend_v_q;
		rate_cnt_d = rate_cnt_q;
		if (strobe2) begin
			rate_cnt_d = (mode_q != TAC_NORMAL || rate_hit) ? '0 : rate_next;
		end
		if (tooth_evt && last_q) begin
			angle_cnt_d = '0;
			left_d   = span;
			mode_d   = TAC_NORMAL;
			pend_v_d = 1'b0;
		end else if (tooth_evt && left_dec != '0) begin
			// early tooth: catch up; a second early tooth replaces the pending span
			mode_d   = TAC_HIGH;
			pend_d   = span;
			pend_v_d = 1'b1;
		end else if (tooth_evt) begin
			left_d   = span;
			mode_d   = TAC_NORMAL;
		end else if (angle_tick && left_q == {{(TAC_LEFT_W-1){1'b0}}, 1'b1}) begin
			// end of high rate only reloads; flag and counter are left alone
			if (mode_q == TAC_HIGH) begin
				mode_d   = TAC_NORMAL;
				left_d   = pend_q;
				pend_v_d = 1'b0;
			end else begin
				mode_d   = TAC_HALT;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q    <= TAC_HALT;
			angle_cnt_q <= '0;
			left_q    <= '0;
			pend_q    <= '0;
			pend_v_q  <= 1'b0;
			rate_cnt_q <= '0;
		end else begin
			mode_q    <= mode_d;
			angle_cnt_q <= angle_cnt_d;
			left_q    <= left_d;
			pend_q    <= pend_d;
			pend_v_q  <= pend_v_d;
			rate_cnt_q <= rate_cnt_d;
		end
	end

	// export copies every internal value, so the bus never skips either
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shared_time_counter_bus <= '0;
			shared_bus_valid        <= 1'b0;
		end else begin
			shared_bus_valid <= export_q;
			if (export_q) begin
				shared_time_counter_bus <= angle_cnt_q;
			end
		end
	end

	a_last_reset: assert property (@(posedge pclk) disable iff (!presetn)
		tooth_evt && last_q |=> angle_cnt_q == '0 && mode_q == TAC_NORMAL)
		else $error("last tooth did not reset second counter");

	a_last_consumed: assert property (@(posedge pclk) disable iff (!presetn)
		tooth_evt && last_q && !wr_tooth |=> !last_q)
		else $error("last flag not cleared after last tooth");

	a_high_keeps_last: assert property (@(posedge pclk) disable iff (!presetn)
		mode_q == TAC_HIGH && last_q && !tooth_evt && !wr_tooth |=> last_q)
		else $error("last flag lost during high rate");

	a_high_exit_clean: assert property (@(posedge pclk) disable iff (!presetn)
		mode_q == TAC_HIGH && !tooth_evt && !wr_tooth ##1 mode_q == TAC_NORMAL
		|-> angle_cnt_q == $past(angle_cnt_q) + 1 && last_q == $past(last_q))
		else $error("leaving high rate disturbed counter or flag");

	a_miss_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!wr_tooth |=> $stable(miss_q))
		else $error("missing tooth count changed without write");

	a_presc_order: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(tb_en_q) |-> !tb_en_d1_q ##1 tb_en_d1_q)
		else $error("second prescaler not started one clock after first");

	a_export_copy: assert property (@(posedge pclk) disable iff (!presetn)
		export_q |=> shared_bus_valid && shared_time_counter_bus == $past(angle_cnt_q))
		else $error("shared bus does not follow second counter");

	a_angle_step: assert property (@(posedge pclk) disable iff (!presetn)
		!(tooth_evt && last_q) |=> angle_cnt_q == $past(angle_cnt_q) || angle_cnt_q == $past(angle_cnt_q) + 1)
		else $error("second counter skipped a count");

	a_halt_done: assert property (@(posedge pclk) disable iff (!presetn)
		mode_q == TAC_NORMAL && angle_tick && left_q == 1 && !tooth_evt |=> mode_q == TAC_HALT)
		else $error("normal mode did not halt after last tick");

	a_mode_legal: assert property (@(posedge pclk) disable iff (!presetn)
		mode_q != 2'b11)
		else $error("illegal mode code");
endmodule

// [dv/tac_tooth_wheel.sv]
/*
 tooth wheel sensor model: one high pulse on the tooth pin per fire request.
 assumes fire is a one-clock request on pclk; pin idles low between teeth.
*/
module tac_tooth_wheel #(
	parameter int HIGH_CLKS = 3
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic fire,
	output logic      tooth_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] hold_q;

	// pulse kept above two clocks so the synchroniser cannot miss it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			hold_q <= 4'h0;
		else if (fire && hold_q == 4'h0)
			hold_q <= 4'(HIGH_CLKS);
		else if (hold_q != 4'h0)
			hold_q <= hold_q - 4'h1;
	end

	// sensor line is pulled low while no tooth passes
	assign tooth_pin = (hold_q != 4'h0);
endmodule

// [dv/tac_tooth_angle_counter_test.sv]
/*
 self-checking bench for the tooth angle counter: apb tasks and tooth scenarios.
 assumes the one-wait apb slave and the register map of tac_pkg.
*/
module tac_tooth_angle_counter_test;
	timeunit 1ns;
	timeprecision 1ps;
	import tac_pkg::*;

	logic                  pclk, presetn, psel, penable, pwrite, fire, tooth_pin;
	logic                  pready, pslverr, shared_bus_valid, err;
	logic [TAC_ADDR_W-1:0] paddr;
	logic [31:0]           pwdata, prdata, rd;
	logic [TAC_CNT_W-1:0]  first_timebase_counter, shared_time_counter_bus, ftc0;
	int                    miscompares, samples_checked;

	tac_tooth_angle_counter tac_tooth_angle_counter_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .tooth_pin, .first_timebase_counter, .shared_time_counter_bus,
		.shared_bus_valid);
	tac_tooth_wheel tac_tooth_wheel_inst (.pclk, .presetn, .fire, .tooth_pin);

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_bit(input string what, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n == 50) begin
			check_bit("apb ready", 1'b1, 1'b0);
			complete_run();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		check_word(what, exp, rd & m);
	endtask

	task automatic tooth();
		fire <= 1'b1;
		@(posedge pclk);
		fire <= 1'b0;
		repeat (6) @(posedge pclk);
	endtask

	// polls status; bounded so a stuck mode ends the run
	task automatic wait_halt();
		int n;
		n = 0;
		do begin
			apb(1'b0, OFF_STATUS, 32'h0000_0000);
			n++;
		end while (rd[1:0] !== 2'b10 && n < 100);
		if (n == 100) begin
			check_bit("halt reached", 1'b1, 1'b0);
			complete_run();
		end
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		fire = 1'b0;
		miscompares = 0;
		samples_checked = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk("ctrl reset", OFF_CTRL, 32'hffff_ffff, 32'h0001_0100);
		rd_chk("tooth reset", OFF_TOOTH, 32'hffff_ffff, 32'h0000_0000);
		rd_chk("rate reset", OFF_RATE, 32'hffff_ffff, 32'h0000_0001);
		rd_chk("tpt reset", OFF_TPT, 32'hffff_ffff, 32'h0000_0001);
		rd_chk("status reset", OFF_STATUS, 32'hffff_ffff, 32'h0000_0002);
		rd_chk("unmapped data", 8'h20, 32'hffff_ffff, 32'h0000_0000);
		check_bit("unmapped error", 1'b1, err);
		check_word("first count idle", 32'h0, {8'h00, first_timebase_counter});
		apb(1'b1, OFF_TPT, 32'h0000_0004);
		apb(1'b1, OFF_TOOTH, 32'h0000_0000);
		apb(1'b1, OFF_CTRL, 32'h0001_0103);
		// first strobe needs a microcycle after enable, so open the window past it
		repeat (4) @(posedge pclk);
		ftc0 = first_timebase_counter;
		repeat (20) @(posedge pclk);
		check_word("first count rate", {8'h00, 24'(ftc0 + 24'(20 / TAC_MICRO_CLKS))},
			{8'h00, first_timebase_counter});
		check_bit("bus valid", 1'b1, shared_bus_valid);
		tooth();
		wait_halt();
		rd_chk("angle first span", OFF_ANGLE, 32'hffff_ffff, 32'h0000_0004);
		check_word("bus first span", 32'h4, {8'h00, shared_time_counter_bus});
		tooth();
		wait_halt();
		rd_chk("angle no last", OFF_ANGLE, 32'hffff_ffff, 32'h0000_0008);
		apb(1'b1, OFF_TOOTH, 32'h0000_0001);
		tooth();
		wait_halt();
		rd_chk("angle after last", OFF_ANGLE, 32'hffff_ffff, 32'h0000_0004);
		rd_chk("last cleared", OFF_TOOTH, 32'hffff_ffff, 32'h0000_0000);
		// second tooth arrives with ticks left, forcing high rate mode
		apb(1'b1, OFF_TPT, 32'h0000_0028);
		tooth();
		tooth();
		rd_chk("mode high", OFF_STATUS, 32'h0000_0003, 32'h0000_0001);
		apb(1'b1, OFF_TOOTH, 32'h0000_0101);
		wait_halt();
		rd_chk("tooth kept", OFF_TOOTH, 32'hffff_ffff, 32'h0000_0101);
		rd_chk("angle no reset", OFF_ANGLE, 32'hffff_ffff, 32'h0000_0054);
		check_word("bus no skip", 32'h54, {8'h00, shared_time_counter_bus});
		apb(1'b1, OFF_ANGLE, 32'hffff_ffff);
		rd_chk("angle read only", OFF_ANGLE, 32'hffff_ffff, 32'h0000_0054);
		// rewrites made from halt, away from high rate; strobes per tick raised from one to two
		apb(1'b1, OFF_TPT, 32'h0000_000a);
		apb(1'b1, OFF_RATE, 32'h0000_0002);
		apb(1'b1, OFF_TOOTH, 32'h0000_0101);
		tooth();
		wait_halt();
		rd_chk("angle missing span", OFF_ANGLE, 32'hffff_ffff, 32'h0000_0014);
		rd_chk("count kept", OFF_TOOTH, 32'hffff_ffff, 32'h0000_0100);
		check_bit("bus not behind", 1'b1, shared_time_counter_bus >= 24'h000014);
		check_word("bus slow rate", 32'h14, {8'h00, shared_time_counter_bus});
		complete_run();
	end
endmodule
